// ===== fsc_pkg.sv
// fsc_pkg: constants and carriers for the synthesizer control block
package fsc_pkg;

    // control codes in word bits 2:0
    localparam logic [2:0] CTL_INT_FRAC = 3'h0;
    localparam logic [2:0] CTL_FRAC_LOW = 3'h1;
    localparam logic [2:0] CTL_REF_DIV  = 3'h2;
    localparam logic [2:0] CTL_FUNC     = 3'h3;
    localparam logic [2:0] CTL_TEST     = 3'h4;

    localparam int WORD_W = 32;
    localparam int CTL_HI = 2;

    // integer/fraction word fields
    localparam int IF_MUX_HI  = 30;
    localparam int IF_MUX_LO  = 27;
    localparam int IF_INT_HI  = 26;
    localparam int IF_INT_LO  = 15;
    localparam int IF_FMSB_HI = 14;
    localparam int IF_FMSB_LO = 3;
    // fraction low word field
    localparam int FL_FLSB_HI = 27;
    localparam int FL_FLSB_LO = 15;
    localparam int FRAC_LSB_W = 13;
    localparam int FRAC_W     = 25;

    // reference divider word fields
    localparam int RD_SLIP   = 28;
    localparam int RD_CPI_HI = 27;
    localparam int RD_CPI_LO = 24;
    localparam int RD_PRESC  = 22;
    localparam int RD_HALF   = 21;
    localparam int RD_DBL    = 20;
    localparam int RD_RC_HI  = 19;
    localparam int RD_RC_LO  = 15;

    // function word fields
    localparam int FN_SD_HOLD = 14;
    localparam int FN_LDP     = 7;
    localparam int FN_POL     = 6;
    localparam int FN_PD      = 5;
    localparam int FN_CP3     = 4;
    localparam int FN_CRST    = 3;

    // lock detect and slip figures
    localparam int LOCK_CYC_LO     = 24;
    localparam int LOCK_CYC_HI     = 40;
    localparam int LOCK_WIN_NS     = 15;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int LOCK_WIN_RAW    = LOCK_WIN_NS / CLK_PERIOD_NS;
    localparam int LOCK_WIN_CYC    = (LOCK_WIN_RAW < 1) ? 1 : LOCK_WIN_RAW;
    localparam int SLIP_CELLS_MAX  = 7;
    localparam int R_DIV_MAX       = 32;

    typedef struct packed {
        logic       slip_reduction_enable;
        logic [3:0] cp_current;
        logic       prescaler_89;
        logic       reference_halving;
        logic       ref_double;
        logic [4:0] r_count;
    } fsc_div_cfg_t;

    typedef struct packed {
        logic sd_reset_hold;
        logic lock_precision_select;
        logic pd_polarity_pos;
        logic power_down;
        logic cp_tristate;
        logic counter_reset;
    } fsc_func_cfg_t;

    localparam fsc_div_cfg_t  DIV_CFG_RESET  = '0;
    localparam fsc_func_cfg_t FUNC_CFG_RESET = '0;

endpackage

// ===== fsc_control.sv
// fsc_control: serial word capture, reference path and lock detect
`timescale 1ns/100ps

module fsc_control
    import fsc_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          sclk_pin,
    input  wire logic          sdata_pin,
    input  wire logic          latch_strobe_pin,
    input  wire logic          ref_in_pin,
    input  wire logic          feedback_input,
    output fsc_div_cfg_t       div_cfg,
    output fsc_func_cfg_t      func_cfg,
    output logic [3:0]         mux_select,
    output logic [11:0]        int_value,
    output logic [FRAC_W-1:0]  frac_value,
    output logic [WORD_W-1:0]  test_word,
    output logic               sd_reset,
    output logic               pfd_ref,
    output logic               counter_load,
    output logic               cp_hiz,
    output logic               lock_detect,
    output logic [2:0]         slip_cells
);

    localparam int NPIN = 5;
    if (SYNC_STAGES != 2)
        $error("fsc_control: SYNC_STAGES must be 2");

    // two-flop synchronisers; stage 0 feeds only stage 1
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync0_q;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] prev_q;

    assign pin_raw = {feedback_input, ref_in_pin, latch_strobe_pin, sdata_pin, sclk_pin};

    logic sclk_rise;
    logic sdata_s;
    logic lat_rise;
    logic ref_rise;
    logic ref_fall;
    logic fb_rise;

    // serial clock must stay well below clock/4 to be seen here
    assign sclk_rise = sync1_q[0] & ~prev_q[0];
    assign sdata_s   = sync1_q[1];
    assign lat_rise  = sync1_q[2] & ~prev_q[2];
    assign ref_rise  = sync1_q[3] & ~prev_q[3];
    assign ref_fall  = ~sync1_q[3] & prev_q[3];
    assign fb_rise   = sync1_q[4] & ~prev_q[4];

    logic [WORD_W-1:0]     shift_q, shift_d;
    fsc_div_cfg_t          div_sh_q, div_sh_d, div_act_q, div_act_d;
    fsc_func_cfg_t         func_sh_q, func_sh_d, func_act_q, func_act_d;
    logic [3:0]            mux_q, mux_d;
    logic [11:0]           int_q, int_d;
    logic [11:0]           fmsb_q, fmsb_d;
    logic [FRAC_LSB_W-1:0] flsb_q, flsb_d;
    logic [WORD_W-1:0]     test_q, test_d;
    logic                  sdrst_q, sdrst_d;
    logic [5:0]            rcnt_q, rcnt_d;
    logic                  half_q, half_d;
    logic                  pfd_q, pfd_d;
    logic [3:0]            since_fb_q, since_fb_d;
    logic [3:0]            pend_q, pend_d;
    logic [5:0]            lock_cnt_q, lock_cnt_d;
    logic                  lock_q, lock_d;
    logic [2:0]            slip_q, slip_d;
    logic       ref_act;
    logic       r_tick;
    logic       pfd_tick;
    logic       hold;
    logic       apply;
    logic       good_cyc;
    logic       bad_cyc;
    logic [5:0] r_div;
    logic [5:0] lock_need;
    logic       fb_near;
    function automatic logic [5:0] div_ratio(input logic [4:0] code);
        div_ratio = (code == 5'h00) ? 6'(R_DIV_MAX) : {1'b0, code};
    endfunction

    always_comb
    begin
        shift_d    = shift_q;
        div_sh_d   = div_sh_q;
        func_sh_d  = func_sh_q;
        mux_d      = mux_q;
        int_d      = int_q;
        fmsb_d     = fmsb_q;
        flsb_d     = flsb_q;
        test_d     = test_q;
        sdrst_d    = 1'b0;
        if (sclk_rise)
            shift_d = {shift_q[WORD_W-2:0], sdata_s};
        if (lat_rise)
        begin
            unique case (shift_q[CTL_HI:0])
                CTL_INT_FRAC:
                begin
                    mux_d   = shift_q[IF_MUX_HI:IF_MUX_LO];
                    int_d   = shift_q[IF_INT_HI:IF_INT_LO];
                    fmsb_d  = shift_q[IF_FMSB_HI:IF_FMSB_LO];
                    sdrst_d = ~func_sh_q.sd_reset_hold;
                end
                CTL_FRAC_LOW:
                    flsb_d = shift_q[FL_FLSB_HI:FL_FLSB_LO];
                CTL_REF_DIV:
                begin
                    div_sh_d.slip_reduction_enable = shift_q[RD_SLIP];
                    div_sh_d.cp_current        = shift_q[RD_CPI_HI:RD_CPI_LO];
                    div_sh_d.prescaler_89      = shift_q[RD_PRESC];
                    div_sh_d.reference_halving = shift_q[RD_HALF];
                    div_sh_d.ref_double        = shift_q[RD_DBL];
                    div_sh_d.r_count           = shift_q[RD_RC_HI:RD_RC_LO];
                end
                CTL_FUNC:
                begin
                    func_sh_d.sd_reset_hold         = shift_q[FN_SD_HOLD];
                    func_sh_d.lock_precision_select = shift_q[FN_LDP];
                    func_sh_d.pd_polarity_pos       = shift_q[FN_POL];
                    func_sh_d.power_down            = shift_q[FN_PD];
                    func_sh_d.cp_tristate           = shift_q[FN_CP3];
                    func_sh_d.counter_reset         = shift_q[FN_CRST];
                end
                CTL_TEST:
                    test_d = shift_q;
                default:
                    shift_d = shift_d;
            endcase
        end
    end

    // reference path
    assign hold     = func_act_q.power_down | func_act_q.counter_reset;
    assign ref_act  = div_act_q.ref_double ? (ref_rise | ref_fall) : ref_fall;
    assign r_div    = div_ratio(div_act_q.r_count);
    assign r_tick   = ~hold & ref_act & (rcnt_q == r_div - 6'h01);
    assign pfd_tick = r_tick & (~div_act_q.reference_halving | ~half_q);
    // power-down and counter reset must not wait for a reference edge that never comes
    assign apply    = pfd_tick | hold | func_sh_q.power_down | func_sh_q.counter_reset;

    always_comb
    begin
        div_act_d  = apply ? div_sh_q : div_act_q;
        func_act_d = apply ? func_sh_q : func_act_q;
        rcnt_d     = rcnt_q;
        half_d     = half_q;
        pfd_d      = pfd_tick;
        if (hold)
        begin
            rcnt_d = 6'h00;
            half_d = 1'b0;
            pfd_d  = 1'b0;
        end
        else if (ref_act)
        begin
            rcnt_d = r_tick ? 6'h00 : rcnt_q + 6'h01;
            if (r_tick)
                half_d = div_act_q.reference_halving & ~half_q;
        end
    end

    // lock detect and slip cells
    assign lock_need = func_act_q.lock_precision_select ? 6'(LOCK_CYC_HI) : 6'(LOCK_CYC_LO);
    // feedback in the tick's own cycle counts too, else aligned edges never lock
    assign fb_near   = fb_rise | (since_fb_q < 4'(LOCK_WIN_CYC));
    assign good_cyc  = (pfd_tick & fb_near) | ((pend_q != 4'h0) & fb_rise);
    assign bad_cyc   = (pend_q == 4'h1) & ~fb_rise;

    always_comb
    begin
        since_fb_d = fb_rise ? 4'h0 : ((since_fb_q == 4'hF) ? since_fb_q : since_fb_q + 4'h1);
        pend_d     = (pend_q != 4'h0) ? (fb_rise ? 4'h0 : pend_q - 4'h1) : pend_q;
        lock_cnt_d = lock_cnt_q;
        lock_d     = lock_q;
        slip_d     = slip_q;
        if (pfd_tick && !fb_near)
            pend_d = 4'(LOCK_WIN_CYC);
        if (good_cyc)
        begin
            if (lock_cnt_q < lock_need)
                lock_cnt_d = lock_cnt_q + 6'h01;
            lock_d = (lock_cnt_q + 6'h01 >= lock_need);
            if (slip_q != 3'h0)
                slip_d = slip_q - 3'h1;
        end
        else if (bad_cyc)
        begin
            lock_cnt_d = 6'h00;
            lock_d     = 1'b0;
            if (div_act_q.slip_reduction_enable && slip_q < 3'(SLIP_CELLS_MAX))
                slip_d = slip_q + 3'h1;
        end
        if (hold)
        begin
            pend_d     = 4'h0;
            lock_cnt_d = 6'h00;
            lock_d     = 1'b0;
            slip_d     = 3'h0;
        end
        if (!div_act_q.slip_reduction_enable)
            slip_d = 3'h0;
    end

    // configuration is cleared only by rst; power-down leaves it intact
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sync0_q    <= '0;
            sync1_q    <= '0;
            prev_q     <= '0;
            shift_q    <= '0;
            div_sh_q   <= DIV_CFG_RESET;
            func_sh_q  <= FUNC_CFG_RESET;
            div_act_q  <= DIV_CFG_RESET;
            func_act_q <= FUNC_CFG_RESET;
            mux_q      <= 4'h0;
            int_q      <= 12'h000;
            fmsb_q     <= 12'h000;
            flsb_q     <= '0;
            test_q     <= '0;
            sdrst_q    <= 1'b0;
            rcnt_q     <= 6'h00;
            half_q     <= 1'b0;
            pfd_q      <= 1'b0;
            since_fb_q <= 4'hF;
            pend_q     <= 4'h0;
            lock_cnt_q <= 6'h00;
            lock_q     <= 1'b0;
            slip_q     <= 3'h0;
        end
        else
        begin
            sync0_q    <= pin_raw;
            sync1_q    <= sync0_q;
            prev_q     <= sync1_q;
            shift_q    <= shift_d;
            div_sh_q   <= div_sh_d;
            func_sh_q  <= func_sh_d;
            div_act_q  <= div_act_d;
            func_act_q <= func_act_d;
            mux_q      <= mux_d;
            int_q      <= int_d;
            fmsb_q     <= fmsb_d;
            flsb_q     <= flsb_d;
            test_q     <= test_d;
            sdrst_q    <= sdrst_d;
            rcnt_q     <= rcnt_d;
            half_q     <= half_d;
            pfd_q      <= pfd_d;
            since_fb_q <= since_fb_d;
            pend_q     <= pend_d;
            lock_cnt_q <= lock_cnt_d;
            lock_q     <= lock_d;
            slip_q     <= slip_d;
        end
    end

    assign div_cfg      = div_act_q;
    assign func_cfg     = func_act_q;
    assign mux_select   = mux_q;
    assign int_value    = int_q;
    assign frac_value   = {fmsb_q, flsb_q};
    assign test_word    = test_q;
    assign sd_reset     = sdrst_q;
    assign pfd_ref      = pfd_q;
    assign counter_load = hold;
    assign cp_hiz       = func_act_q.power_down | func_act_q.cp_tristate;
    assign lock_detect  = lock_q;
    assign slip_cells   = slip_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_shift_in_bit: assert property (sclk_rise |=> shift_q[0] == $past(sdata_s))
        else $error("serial bit not shifted in");
    chk_func_load: assert property ((lat_rise && shift_q[2:0] == CTL_FUNC)
        |=> func_sh_q.power_down == $past(shift_q[FN_PD])
            && func_sh_q.pd_polarity_pos == $past(shift_q[FN_POL]))
        else $error("function word not loaded");
    chk_test_load: assert property ((lat_rise && shift_q[2:0] == CTL_TEST)
        |=> test_q == $past(shift_q))
        else $error("test word not loaded");
    chk_sd_reset: assert property ((lat_rise && shift_q[2:0] == CTL_INT_FRAC)
        |=> sd_reset == !$past(func_sh_q.sd_reset_hold))
        else $error("modulator reset policy broken");
    chk_lock_count: assert property (lock_q |-> lock_cnt_q == lock_need)
        else $error("lock asserted early");
    chk_bad_restart: assert property (bad_cyc |=> !lock_q && lock_cnt_q == 6'h00)
        else $error("lock count not restarted");
    chk_hold_clears: assert property (hold |=> !pfd_q && rcnt_q == 6'h00 && !lock_q)
        else $error("hold did not clear counters");
    chk_rcnt_range: assert property (rcnt_q < r_div || $changed(div_act_q))
        else $error("reference counter out of range");
    chk_edge_select: assert property (!div_act_q.ref_double && ref_rise |-> !ref_act)
        else $error("rising edge used without doubler");
    chk_apply_point: assert property (!apply |=> $stable(div_act_q))
        else $error("settings changed mid cycle");
    chk_slip_bound: assert property (!div_act_q.slip_reduction_enable |=> slip_q == 3'h0)
        else $error("slip cells without enable");

endmodule // fsc_control

// ===== fsc_host_model.sv
// fsc_host_model: host side of the three-wire serial write port
`timescale 1ns/100ps
module fsc_host_model
    import fsc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              req,
    input  wire logic [WORD_W-1:0] word,
    output logic                   done,
    output logic                   sclk_pin,
    output logic                   sdata_pin,
    output logic                   latch_strobe_pin
);
    initial
    begin
        done             = 1'b0;
        sclk_pin         = 1'b0;
        sdata_pin        = 1'b0;
        latch_strobe_pin = 1'b0;
    end

    // 4-clock phases: the pins pass synchronisers needing 3 clocks a phase
    always
    begin
        @(posedge clock);
        if (req === 1'b1)
        begin
            for (int i = WORD_W - 1; i >= 0; i--)
            begin
                sdata_pin <= word[i];
                repeat (4) @(posedge clock);
                sclk_pin <= 1'b1;
                repeat (4) @(posedge clock);
                sclk_pin <= 1'b0;
            end
            // released data line shows the inverse, never a stale bit
            sdata_pin <= ~word[0];
            repeat (4) @(posedge clock);
            latch_strobe_pin <= 1'b1;
            repeat (4) @(posedge clock);
            latch_strobe_pin <= 1'b0;
            repeat (4) @(posedge clock);
            done <= 1'b1;
            @(posedge clock);
            done <= 1'b0;
            while (req === 1'b1)
                @(posedge clock);
        end
    end
endmodule // fsc_host_model

// ===== test_fracn_synth_control_regs.sv
// test_fracn_synth_control_regs: self-checking bench for fsc_control
`timescale 1ns/100ps
module test_fracn_synth_control_regs
    import fsc_pkg::*;
;
    logic              clock = 1'b0, rst = 1'b1, req = 1'b0, fb_en = 1'b0;
    logic              ref_in_pin = 1'b0, feedback_input = 1'b0;
    logic [WORD_W-1:0] word = '0;
    logic [3:0]        rcnt = 4'h0;
    logic              done, sclk_pin, sdata_pin, latch_strobe_pin;
    fsc_div_cfg_t      div_cfg;
    fsc_func_cfg_t     func_cfg;
    logic [3:0]        mux_select;
    logic [11:0]       int_value;
    logic [FRAC_W-1:0] frac_value;
    logic [WORD_W-1:0] test_word;
    logic              sd_reset, pfd_ref, counter_load, cp_hiz, lock_detect;
    logic [2:0]        slip_cells;
    int                failures = 0, compares = 0, cycles = 0, sd_cnt = 0;

    fsc_host_model u_fsc_host_model (.clock(clock), .req(req), .word(word), .done(done),
        .sclk_pin(sclk_pin), .sdata_pin(sdata_pin), .latch_strobe_pin(latch_strobe_pin));

    fsc_control #(.SYNC_STAGES(2)) u_fsc_control (.clock(clock), .rst(rst),
        .sclk_pin(sclk_pin), .sdata_pin(sdata_pin), .latch_strobe_pin(latch_strobe_pin),
        .ref_in_pin(ref_in_pin), .feedback_input(feedback_input), .div_cfg(div_cfg),
        .func_cfg(func_cfg), .mux_select(mux_select), .int_value(int_value),
        .frac_value(frac_value), .test_word(test_word), .sd_reset(sd_reset),
        .pfd_ref(pfd_ref), .counter_load(counter_load), .cp_hiz(cp_hiz),
        .lock_detect(lock_detect), .slip_cells(slip_cells));

    always #10 clock = ~clock;

    // reference of 16 clocks, 3.125 MHz, low enough for the doubler
    always @(posedge clock)
    begin
        rcnt           <= rcnt + 4'h1;
        ref_in_pin     <= rcnt[3];
        feedback_input <= fb_en & ~rcnt[3];
        if (sd_reset === 1'b1)
            sd_cnt <= sd_cnt + 1;
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failures = failures + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] fw(input logic [4:0] b, input logic hold);
        return {17'h0, hold, 6'h0, b, CTL_FUNC};
    endfunction

    function automatic logic [31:0] dw(input logic [12:0] c);
        return {3'h0, c[12:8], 1'b0, c[7:0], 12'h0, CTL_REF_DIV};
    endfunction

    function automatic logic [31:0] iw(input logic [3:0] m, input logic [11:0] i,
                                       input logic [11:0] f);
        return {1'b0, m, i, f, CTL_INT_FRAC};
    endfunction

    task automatic wr(input logic [31:0] w);
        int n;
        req  <= 1'b1;
        word <= w;
        for (n = 0; n < 400 && done !== 1'b1; n++)
            @(posedge clock);
        check({31'h0, n < 400}, 32'h1);
        req <= 1'b0;
        @(posedge clock);
    endtask

    // settings take effect at a reference tick, so allow two slow periods
    task automatic apply_div(input logic [12:0] c);
        int n;
        wr(dw(c));
        for (n = 0; n < 1200 && div_cfg !== c; n++)
            @(posedge clock);
        check({19'h0, div_cfg}, {19'h0, c});
    endtask

    task automatic apply_fn(input logic [4:0] b, input logic hold);
        int n;
        wr(fw(b, hold));
        for (n = 0; n < 1200 && func_cfg !== {hold, b}; n++)
            @(posedge clock);
        check({26'h0, func_cfg}, {26'h0, hold, b});
    endtask

    task automatic period(output int p);
        int n;
        for (n = 0; n < 1200 && pfd_ref !== 1'b1; n++)
            @(posedge clock);
        @(posedge clock);
        for (p = 1; p < 1200 && pfd_ref !== 1'b1; p++)
            @(posedge clock);
    endtask

    task automatic t_init();
        int s;
        wr({29'h0, CTL_TEST});
        check(test_word, {29'h0, CTL_TEST});
        apply_fn(5'h00, 1'b0);
        apply_div({1'b0, 4'h7, 3'h0, 5'd1});
        wr({4'h0, 13'd7537, 12'h0, CTL_FRAC_LOW});
        s = sd_cnt;
        wr(iw(4'h3, 12'd580, 12'd81));
        check({20'h0, int_value}, 32'd580);
        check({28'h0, mux_select}, 32'h3);
        check({7'h0, frac_value}, 32'd81 * 32'd8192 + 32'd7537);
        check(sd_cnt - s, 32'h1);
        apply_fn(5'h00, 1'b1);
        s = sd_cnt;
        wr(iw(4'h3, 12'd580, 12'd81));
        check(sd_cnt - s, 32'h0);
        $display("test init finished");
    endtask

    task automatic t_ref();
        logic [12:0] cf[5] = '{{1'b0, 4'h0, 3'b000, 5'd1}, {1'b0, 4'h5, 3'b001, 5'd1},
                               {1'b0, 4'hA, 3'b010, 5'd1}, {1'b0, 4'hF, 3'b100, 5'd5},
                               {1'b0, 4'h3, 3'b000, 5'd0}};
        int pe[5] = '{16, 8, 32, 80, 512};
        int p;
        for (int i = 0; i < 5; i++)
        begin
            apply_div(cf[i]);
            period(p);
            period(p);
            check(p, pe[i]);
        end
        apply_div({1'b0, 4'h7, 3'h0, 5'd1});
        $display("test reference path finished");
    endtask

    task automatic t_lock();
        int n, k, lim;
        for (int l = 0; l < 2; l++)
        begin
            lim = (l == 1) ? 40 : 24;
            fb_en <= 1'b0;
            apply_fn({l[0], 4'h0}, 1'b0);
            repeat (40) @(posedge clock);
            check({31'h0, lock_detect}, 32'h0);
            while (rcnt[3] !== 1'b1)
                @(posedge clock);
            fb_en <= 1'b1;
            for (k = 0, n = 0; k < 2000 && lock_detect !== 1'b1; k++)
            begin
                @(posedge clock);
                if (pfd_ref === 1'b1)
                    n++;
            end
            check({31'h0, n >= lim - 1 && n <= lim + 1}, 32'h1);
            fb_en <= 1'b0;
            for (k = 0; k < 40 && lock_detect !== 1'b0; k++)
                @(posedge clock);
            check({31'h0, lock_detect}, 32'h0);
        end
        $display("test lock detect finished");
    endtask

    task automatic t_slip();
        int k;
        apply_fn(5'b01000, 1'b0);
        apply_div({1'b1, 4'h7, 3'h0, 5'd1});
        for (k = 0; k < 600 && slip_cells !== 3'h7; k++)
            @(posedge clock);
        repeat (100) @(posedge clock);
        check({29'h0, slip_cells}, 32'h7);
        fb_en <= 1'b1;
        for (k = 0; k < 600 && slip_cells !== 3'h0; k++)
            @(posedge clock);
        check({29'h0, slip_cells}, 32'h0);
        $display("test slip reduction finished");
    endtask

    task automatic t_power();
        int k, n;
        for (k = 0; k < 1000 && lock_detect !== 1'b1; k++)
            @(posedge clock);
        wr(fw(5'b01100, 1'b0));
        repeat (2) @(posedge clock);
        check({29'h0, counter_load, cp_hiz, lock_detect}, 32'h6);
        for (n = 0, k = 0; k < 100; k++)
        begin
            @(posedge clock);
            if (pfd_ref === 1'b1)
                n++;
        end
        check(n, 32'h0);
        check({19'h0, div_cfg}, {19'h0, 1'b1, 4'h7, 3'h0, 5'd1});
        wr(iw(4'h5, 12'd75, 12'd1));
        check({20'h0, int_value}, 32'd75);
        apply_fn(5'b01000, 1'b0);
        for (k = 0; k < 1000 && lock_detect !== 1'b1; k++)
            @(posedge clock);
        check({29'h0, counter_load, cp_hiz, lock_detect}, 32'h1);
        $display("test power-down finished");
    endtask

    task automatic t_ctl();
        apply_fn(5'b01010, 1'b0);
        check({30'h0, counter_load, cp_hiz}, 32'h1);
        apply_fn(5'b01001, 1'b0);
        check({30'h0, counter_load, cp_hiz}, 32'h2);
        apply_fn(5'b01000, 1'b0);
        for (int c = 5; c < 8; c++)
            wr({29'h01234567, c[2:0]});
        check(test_word, {29'h0, CTL_TEST});
        check({20'h0, int_value}, 32'd75);
        $display("test control bits finished");
    endtask

    initial
    begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_init();
        t_ref();
        t_lock();
        t_slip();
        t_power();
        t_ctl();
        end_sim();
    end
endmodule // test_fracn_synth_control_regs
